// ### grt_pkg.sv
// constants, modes and configuration layout for ground ranging timing
// assumes a 125 MHz system clock; all users write grt_pkg::name
package grt_pkg;
    // ranging submodes selected by the radar data processor
    typedef enum logic [1:0] {
        GRT_ACQ = 2'b00,
        GRT_MONO = 2'b01,
        GRT_SPLIT = 2'b10
    } grt_submode_t;

    // event generator run states
    typedef enum logic [1:0] {
        GRT_IDLE = 2'b00,
        GRT_RUN = 2'b01,
        GRT_WAIT = 2'b10
    } grt_state_t;

    // static configuration word driven to radar and conditioner
    typedef struct packed {
        logic blank_en;
        logic short_pulse;
        logic guard_sel;
        logic az_el_sel;
        logic [1:0] ap_mode;
        logic [1:0] bw_ctl;
        logic [1:0] adc_mode;
        logic adc_toggle;
        logic mclk_sel;
        logic prepack_reorder;
        logic canceller_byp;
        logic compressor_byp;
        logic phase_comp_byp;
        logic [1:0] gain_sel;
        logic [2:0] stc_sel;
        logic split_interval;
    } grt_cfg_t;

    // timing, in ns, and derived cycle counts
    localparam int CLK_NS = 8;
    localparam int FULL_BIN_NS = 1000;
    localparam int HALF_BIN_NS = 500;
    localparam int FULL_BIN_CYC = FULL_BIN_NS / CLK_NS;
    localparam int HALF_BIN_CYC = HALF_BIN_NS / CLK_NS;
    localparam int PRI_FULL_NS = 1000000;
    localparam int PRI_BINS = PRI_FULL_NS / FULL_BIN_NS;
    localparam int PROG_LEAD_NS = 300000;
    localparam int LEAD_FULL = PROG_LEAD_NS / FULL_BIN_NS;
    localparam int LEAD_SPLIT = PROG_LEAD_NS / HALF_BIN_NS;

    // intervals per process cycle, sample spans, gain gate length
    localparam int PRIS_FULL = 8;
    localparam int PRIS_SPLIT = 16;
    localparam int SPAN_ACQ = 128;
    localparam int SPAN_MONO = 8;
    localparam int SPAN_SPLIT = 16;
    localparam int DIGITAL_GAIN_CONTROL_BINS = 128;

    // field codes
    localparam logic [1:0] AP_MODE_LOW = 2'h0;
    localparam logic [1:0] BW_500K = 2'h3;
    localparam logic [1:0] ADC_READ_BOTH = 2'h2;
    localparam logic [1:0] GAIN_CALC = 2'h0;
    localparam logic [2:0] STC_OFF = 3'h0;

    // event memory slots
    localparam int EM_START = 0;
    localparam int EM_END = 1;
    localparam int EM_REQ = 2;
    localparam int EM_LAST = 3;
    localparam int EM_SLOTS = 4;
endpackage

// ### grt_timing.sv
// ground ranging interval and process event generators with static config
// assumes mode, range and load strobes come from logic on sys_clk
//
// Overview of operation
// - bin period 1 us, split track 0.5 us
// - transmit starts cycle, enables blanking pulse
// - alternate intervals delayed 500 ns in acq/mono
// - interval sync ends each 1 ms/0.5 ms cycle
// - process generator steps on each interval sync
// - process sync at first interval of cycle
// - process cycle 8 ms: 8 or 16 intervals
// - program request 300 us before cycle end
// - reload done switches memories, starts next cycle
// - host starts first cycle, then block self-governs
// - blanking enable and short pulse held high
// - guard in acq/split; difference, elevation in mono
// - mono phase select toggles every two intervals
// - analog mode 00, bandwidth 11 always
// - acq/mono: read both, four clocks, reorder
// - split: alternate channel, toggle, fifo, two clocks; adc mode stays read both
// - canceller, compressor, phase compensator bypassed
// - gain gate 128 bins, calculated gain, no stc
// - sample window spans 128, 8 or 16 bins
// - start follows coarse range; acq at bin zero
// - mono start at half range; odd adds half
module grt_timing #(
    parameter int CR_W = 10,
    parameter int BIN_W = 11
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // host mode and range
    input wire grt_pkg::grt_submode_t submode,
    input wire logic [CR_W-1:0] coarse_range,
    input wire logic host_execute,
    input wire logic reload_complete,
    // interval events
    output logic transmit_pulse,
    output logic receiver_blank_pulse,
    output logic sample_start_pulse,
    output logic sample_end_pulse,
    output logic sample_window,
    output logic digital_gain_control_gate,
    output logic pulse_interval_sync,
    // process events
    output logic process_sync,
    output logic program_request,
    output logic osc_update,
    output logic execute_mode,
    output logic phase_select,
    output logic readout_channel,
    // static configuration
    output grt_pkg::grt_cfg_t cfg
);
    logic [1:0] rs_q;
    logic rst_n;
    grt_pkg::grt_state_t state_q;
    grt_pkg::grt_submode_t mode_q;
    logic odd_q;
    logic [BIN_W-1:0] em_q [grt_pkg::EM_SLOTS];
    logic [6:0] div_q;
    logic [BIN_W-1:0] bin_q;
    logic [3:0] pri_q;
    logic [1:0] fd_q;
    logic reload_seen_q;
    logic tick_full, tick_half, bin_tick, adv, at_last, pri_last;
    logic cycle_end, reload_ok, tx_fire;
    logic [BIN_W-1:0] bin_next;
    logic [3:0] pri_next;
    logic [BIN_W-1:0] ld [grt_pkg::EM_SLOTS];
    logic [BIN_W-1:0] em_use [grt_pkg::EM_SLOTS];
    grt_pkg::grt_submode_t nxt_mode;
    logic nxt_odd;
    logic [1:0] fd_now;

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rs_q <= 2'h0;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_n = rs_q[1];

    // staged event counts from host mode and range
    always_comb begin
        for (int i = 0; i < grt_pkg::EM_SLOTS; i++) begin
            ld[i] = '0;
        end
        ld[grt_pkg::EM_LAST] = BIN_W'(grt_pkg::PRI_BINS - 1);
        unique case (submode)
            grt_pkg::GRT_MONO: begin
                ld[grt_pkg::EM_START] = BIN_W'(coarse_range >> 1);
                ld[grt_pkg::EM_END] = BIN_W'(coarse_range >> 1)
                    + BIN_W'(grt_pkg::SPAN_MONO);
                ld[grt_pkg::EM_REQ] =
                    BIN_W'(grt_pkg::PRI_BINS - grt_pkg::LEAD_FULL);
            end
            grt_pkg::GRT_SPLIT: begin
                ld[grt_pkg::EM_START] = BIN_W'(coarse_range);
                ld[grt_pkg::EM_END] = BIN_W'(coarse_range)
                    + BIN_W'(grt_pkg::SPAN_SPLIT);
                ld[grt_pkg::EM_REQ] =
                    BIN_W'(grt_pkg::PRI_BINS - grt_pkg::LEAD_SPLIT);
            end
            default: begin
                ld[grt_pkg::EM_START] = '0;
                ld[grt_pkg::EM_END] = BIN_W'(grt_pkg::SPAN_ACQ);
                ld[grt_pkg::EM_REQ] =
                    BIN_W'(grt_pkg::PRI_BINS - grt_pkg::LEAD_FULL);
            end
        endcase
    end

    // counts in force for the coming bin: fresh ones apply at the wrap,
    // so bin zero of a new cycle already sees the new window
    always_comb begin
        for (int i = 0; i < grt_pkg::EM_SLOTS; i++) begin
            em_use[i] = cycle_end ? ld[i] : em_q[i];
        end
    end

    // bin ticks: full bin at phase 0, half bin at mid phase
    assign tick_full = state_q == grt_pkg::GRT_RUN && div_q == 7'h0;
    assign tick_half = state_q == grt_pkg::GRT_RUN
        && div_q == 7'(grt_pkg::HALF_BIN_CYC);
    assign bin_tick = tick_full
        | (tick_half & mode_q == grt_pkg::GRT_SPLIT);
    assign at_last = bin_q == em_q[grt_pkg::EM_LAST];
    assign pri_last = mode_q == grt_pkg::GRT_SPLIT
        ? pri_q == 4'(grt_pkg::PRIS_SPLIT - 1)
        : pri_q == 4'(grt_pkg::PRIS_FULL - 1);
    assign cycle_end = at_last & pri_last;
    assign reload_ok = reload_seen_q | reload_complete;
    assign adv = bin_tick & ~(cycle_end & ~reload_ok);
    assign bin_next = at_last ? '0 : bin_q + BIN_W'(1);
    assign pri_next = pri_last ? 4'h0 : pri_q + 4'h1;
    assign nxt_mode = cycle_end ? submode : mode_q;
    assign nxt_odd = cycle_end ? submode == grt_pkg::GRT_MONO
        && coarse_range[0] : odd_q;
    // fine delay in half bins for the interval about to begin
    assign fd_now = 2'((nxt_mode != grt_pkg::GRT_SPLIT) & pri_next[0])
        + 2'(nxt_odd);
    assign tx_fire = (adv & at_last & fd_now == 2'h0)
        | (tick_half & bin_q == '0 & fd_q == 2'h1)
        | (tick_full & bin_q == '0 & fd_q == 2'h2);

    // run state: host starts, reload completion resumes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= grt_pkg::GRT_IDLE;
        end else if (clk_en) begin
            unique case (state_q)
                grt_pkg::GRT_IDLE: begin
                    if (host_execute) begin
                        state_q <= grt_pkg::GRT_RUN;
                    end
                end
                grt_pkg::GRT_RUN: begin
                    if (bin_tick && cycle_end && !reload_ok) begin
                        state_q <= grt_pkg::GRT_WAIT;
                    end
                end
                grt_pkg::GRT_WAIT: begin
                    if (reload_complete) begin
                        state_q <= grt_pkg::GRT_RUN;
                    end
                end
                default: state_q <= grt_pkg::GRT_IDLE;
            endcase
        end
    end

    // reload seen flag; a new completion wins over the clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_seen_q <= 1'b0;
        end else if (clk_en) begin
            if (reload_complete
                || (state_q == grt_pkg::GRT_IDLE && host_execute)) begin
                reload_seen_q <= 1'b1;
            end else if (adv && cycle_end) begin
                reload_seen_q <= 1'b0;
            end
        end
    end

    // event memory switched to new counts at each cycle wrap
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= grt_pkg::GRT_ACQ;
            odd_q <= 1'b0;
            for (int i = 0; i < grt_pkg::EM_SLOTS; i++) begin
                em_q[i] <= BIN_W'(grt_pkg::PRI_BINS - 1);
            end
        end else if (clk_en && adv && cycle_end) begin
            mode_q <= submode;
            odd_q <= nxt_odd;
            for (int i = 0; i < grt_pkg::EM_SLOTS; i++) begin
                em_q[i] <= ld[i];
            end
        end
    end

    // bin clock divider, runs only while executing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 7'h0;
        end else if (clk_en) begin
            if (state_q != grt_pkg::GRT_RUN
                || div_q == 7'(grt_pkg::FULL_BIN_CYC - 1)) begin
                div_q <= 7'h0;
            end else begin
                div_q <= div_q + 7'h1;
            end
        end
    end

    // interval and process counters; idle parks both on last
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bin_q <= BIN_W'(grt_pkg::PRI_BINS - 1);
            pri_q <= 4'(grt_pkg::PRIS_FULL - 1);
            fd_q <= 2'h0;
        end else if (clk_en && adv) begin
            bin_q <= bin_next;
            if (at_last) begin
                pri_q <= pri_next;
                fd_q <= fd_now;
            end
        end
    end

    // interval event pulses and windows
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_pulse <= 1'b0;
            sample_start_pulse <= 1'b0;
            sample_end_pulse <= 1'b0;
            sample_window <= 1'b0;
            digital_gain_control_gate <= 1'b0;
            pulse_interval_sync <= 1'b0;
        end else if (clk_en) begin
            transmit_pulse <= tx_fire;
            pulse_interval_sync <= adv & at_last;
            sample_start_pulse <= adv
                & bin_next == em_use[grt_pkg::EM_START];
            sample_end_pulse <= adv & bin_next == em_use[grt_pkg::EM_END];
            if (adv && bin_next == em_use[grt_pkg::EM_START]) begin
                sample_window <= 1'b1;
            end else if (adv && bin_next == em_use[grt_pkg::EM_END]) begin
                sample_window <= 1'b0;
            end
            if (adv && at_last) begin
                digital_gain_control_gate <= 1'b1;
            end else if (adv && bin_next == BIN_W'(grt_pkg::DIGITAL_GAIN_CONTROL_BINS)) begin
                digital_gain_control_gate <= 1'b0;
            end
        end
    end
    assign receiver_blank_pulse = transmit_pulse;

    // process generator outputs, stepped by interval sync
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            process_sync <= 1'b0;
            osc_update <= 1'b0;
            program_request <= 1'b0;
            phase_select <= 1'b0;
            readout_channel <= 1'b0;
        end else if (clk_en) begin
            process_sync <= adv & cycle_end;
            osc_update <= adv & at_last;
            if (adv && cycle_end) begin
                program_request <= 1'b0;
            end else if (adv && pri_last
                && bin_next == em_q[grt_pkg::EM_REQ]) begin
                program_request <= 1'b1;
            end
            if (adv && at_last) begin
                phase_select <= nxt_mode == grt_pkg::GRT_MONO
                    && pri_next[1];
                readout_channel <= nxt_mode == grt_pkg::GRT_SPLIT
                    && pri_next[0];
            end
        end
    end
    assign execute_mode = state_q == grt_pkg::GRT_RUN;

    // static configuration from the active submode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= '0;
        end else if (clk_en) begin
            cfg.blank_en <= 1'b1;
            cfg.short_pulse <= 1'b1;
            cfg.guard_sel <= mode_q != grt_pkg::GRT_MONO;
            cfg.az_el_sel <= 1'b1;
            cfg.ap_mode <= grt_pkg::AP_MODE_LOW;
            cfg.bw_ctl <= grt_pkg::BW_500K;
            cfg.adc_mode <= grt_pkg::ADC_READ_BOTH;
            cfg.adc_toggle <= mode_q == grt_pkg::GRT_SPLIT;
            cfg.mclk_sel <= mode_q == grt_pkg::GRT_SPLIT;
            cfg.prepack_reorder <= mode_q != grt_pkg::GRT_SPLIT;
            cfg.canceller_byp <= 1'b1;
            cfg.compressor_byp <= 1'b1;
            cfg.phase_comp_byp <= 1'b1;
            cfg.gain_sel <= grt_pkg::GAIN_CALC;
            cfg.stc_sel <= grt_pkg::STC_OFF;
            cfg.split_interval <= mode_q == grt_pkg::GRT_SPLIT;
        end
    end

    // checks on the generated timing
    property p_split_bin;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(clk_en) |-> cfg.split_interval
            == $past(mode_q == grt_pkg::GRT_SPLIT);
    endproperty
    a_split_bin: assert property (p_split_bin)
        else $error("bin period select wrong");
    property p_sync_gap;
        @(posedge sys_clk) disable iff (!rst_n)
        pulse_interval_sync |=> !pulse_interval_sync [*8];
    endproperty
    a_sync_gap: assert property (p_sync_gap)
        else $error("interval syncs too close");
    property p_osc_step;
        @(posedge sys_clk) disable iff (!rst_n)
        osc_update == pulse_interval_sync;
    endproperty
    a_osc_step: assert property (p_osc_step)
        else $error("oscillator update off interval sync");
    property p_proc_sync;
        @(posedge sys_clk) disable iff (!rst_n)
        process_sync |-> pulse_interval_sync && pri_q == 4'h0;
    endproperty
    a_proc_sync: assert property (p_proc_sync)
        else $error("process sync not at first interval");
    property p_req_end;
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(program_request) |-> process_sync;
    endproperty
    a_req_end: assert property (p_req_end)
        else $error("program request not ended by cycle wrap");
    property p_phase;
        @(posedge sys_clk) disable iff (!rst_n)
        $changed(phase_select) |-> pulse_interval_sync
            && (pri_q[0] == 1'b0);
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase select changed off pair boundary");
    property p_static;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(clk_en) && $past(rst_n) |-> cfg.blank_en && cfg.short_pulse
            && cfg.canceller_byp && cfg.compressor_byp
            && cfg.phase_comp_byp && cfg.bw_ctl == grt_pkg::BW_500K;
    endproperty
    a_static: assert property (p_static)
        else $error("static configuration bit wrong");
    property p_mono_ant;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(clk_en) && $past(rst_n) && $past(mode_q == grt_pkg::GRT_MONO)
            |-> !cfg.guard_sel && cfg.az_el_sel && cfg.prepack_reorder;
    endproperty
    a_mono_ant: assert property (p_mono_ant)
        else $error("monopulse antenna setting wrong");
    property p_window;
        @(posedge sys_clk) disable iff (!rst_n)
        sample_start_pulse && !sample_end_pulse |-> sample_window;
    endproperty
    a_window: assert property (p_window)
        else $error("sample window not opened");
    c_proc: cover property (@(posedge sys_clk) process_sync);
    c_req: cover property (@(posedge sys_clk) $rose(program_request));
    c_wait: cover property (@(posedge sys_clk)
        state_q == grt_pkg::GRT_WAIT);
endmodule

// ### grt_host_model.sv
// behavioural radar data processor facing the ground ranging timing block
// assumes sys_clk at 125 MHz; bench asks for a start through start_req
module grt_host_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // bench control
    input wire logic start_req,
    input wire grt_pkg::grt_submode_t mode_in,
    input wire logic [9:0] range_in,
    input wire logic slow_reload,
    // timing block side
    input wire logic program_request,
    output grt_pkg::grt_submode_t submode,
    output logic [9:0] coarse_range,
    output logic host_execute,
    output logic reload_complete
);
    timeunit 1ns;
    timeprecision 100ps;
    int edges;
    int dly;
    bit started;
    bit req_seen;

    // drive everything 1 ns after the rising edge
    initial begin
        submode = grt_pkg::GRT_ACQ;
        coarse_range = 10'h000;
        host_execute = 1'b0;
        reload_complete = 1'b0;
        forever begin
            @(posedge sys_clk);
            #1;
            host_execute = 1'b0;
            reload_complete = 1'b0;
            if (!arst_n) begin
                edges = 0;
                dly = 0;
                started = 0;
                req_seen = 0;
            end else begin
                edges++;
                // first load and switch to execute come from the host
                if (start_req && !started && edges >= 4) begin
                    submode = mode_in; // held for the whole run
                    coarse_range = range_in; // held for the whole run
                    host_execute = 1'b1;
                    started = 1;
                end
                // answer a reload request promptly or slowly
                if (program_request && !req_seen) begin
                    req_seen = 1;
                    dly = slow_reload ? 2000 : 20;
                end else if (!program_request) begin
                    req_seen = 0;
                end
                if (dly > 0) begin
                    dly--;
                    reload_complete = (dly == 0);
                end
            end
        end
    end
endmodule

// ### ground_ranging_event_timing_test.sv
// self-checking bench for the ground ranging timing block
// assumes grt_host_model as the far side; no count is shortened
module ground_ranging_event_timing_test;
    timeunit 1ns;
    timeprecision 100ps;
    // clock, reset and bench control
    logic sys_clk = 1'b0;
    logic arst_n = 1'b1;
    logic clk_en = 1'b1;
    logic start_req = 1'b0;
    logic slow_reload = 1'b0;
    grt_pkg::grt_submode_t mode_in = grt_pkg::GRT_ACQ;
    logic [9:0] range_in = 10'h000;
    // block ports
    grt_pkg::grt_submode_t submode;
    logic [9:0] coarse_range;
    logic host_execute, reload_complete;
    logic transmit_pulse, receiver_blank_pulse, sample_start_pulse;
    logic sample_end_pulse, sample_window, digital_gain_control_gate, pulse_interval_sync;
    logic process_sync, program_request, osc_update, execute_mode;
    logic phase_select, readout_channel;
    grt_pkg::grt_cfg_t cfg;
    int bad_count = 0;
    int samples_checked = 0;
    int t [0:9];

    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    grt_host_model host_u (.sys_clk(sys_clk), .arst_n(arst_n),
        .start_req(start_req), .mode_in(mode_in), .range_in(range_in),
        .slow_reload(slow_reload), .program_request(program_request),
        .submode(submode), .coarse_range(coarse_range),
        .host_execute(host_execute), .reload_complete(reload_complete));

    grt_timing dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .submode(submode), .coarse_range(coarse_range),
        .host_execute(host_execute), .reload_complete(reload_complete),
        .transmit_pulse(transmit_pulse),
        .receiver_blank_pulse(receiver_blank_pulse),
        .sample_start_pulse(sample_start_pulse),
        .sample_end_pulse(sample_end_pulse), .sample_window(sample_window),
        .digital_gain_control_gate(digital_gain_control_gate), .pulse_interval_sync(pulse_interval_sync),
        .process_sync(process_sync), .program_request(program_request),
        .osc_update(osc_update), .execute_mode(execute_mode),
        .phase_select(phase_select), .readout_channel(readout_channel),
        .cfg(cfg));

    // verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked,
            bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // compare a sampled value
    task automatic check_val(string name, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // compare a cycle count against a window
    task automatic check_cnt(string name, int lo, int hi, int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    // event selector for the cycle stamper
    function automatic logic pick(int k);
        case (k)
            0: pick = transmit_pulse;
            1: pick = sample_start_pulse;
            2: pick = sample_end_pulse;
            3: pick = ~digital_gain_control_gate;
            4: pick = ~sample_window;
            5: pick = pulse_interval_sync;
            6: pick = process_sync;
            7: pick = phase_select;
            8: pick = readout_channel;
            default: pick = receiver_blank_pulse;
        endcase
    endfunction

    // stamp first sighting of each event, stop on one, bounded wait
    task automatic measure(input int bound, input int stop);
        int i;
        for (int k = 0; k < 10; k++) t[k] = -1;
        i = 0;
        while (t[stop] < 0 && i < bound) begin
            @(posedge sys_clk);
            #2;
            i++;
            for (int k = 0; k < 10; k++) begin
                if (t[k] < 0 && pick(k) === 1'b1) t[k] = i;
            end
        end
        if (t[stop] < 0) begin
            bad_count++;
            $display("BAD wait event %0d expected seen timeout", stop);
            finish_test();
        end
    endtask

    // expected configuration and the fields that rules fix
    function automatic logic [31:0] cfg_exp(grt_pkg::grt_submode_t m);
        grt_pkg::grt_cfg_t c;
        bit sp;
        sp = (m == grt_pkg::GRT_SPLIT);
        c = '1;
        c.guard_sel = (m != grt_pkg::GRT_MONO);
        c.ap_mode = grt_pkg::AP_MODE_LOW;
        c.bw_ctl = grt_pkg::BW_500K;
        c.adc_mode = grt_pkg::ADC_READ_BOTH;
        c.adc_toggle = sp;
        c.mclk_sel = sp;
        c.prepack_reorder = !sp;
        c.gain_sel = grt_pkg::GAIN_CALC;
        c.stc_sel = grt_pkg::STC_OFF;
        c.split_interval = sp;
        if (m != grt_pkg::GRT_MONO) c.az_el_sel = 1'b0;
        return 32'(c);
    endfunction

    function automatic logic [31:0] cfg_mask(grt_pkg::grt_submode_t m);
        grt_pkg::grt_cfg_t c;
        c = '1;
        c.az_el_sel = (m == grt_pkg::GRT_MONO);
        return 32'(c);
    endfunction

    // reset, start a submode, stop at the first process sync
    task automatic start_mode(grt_pkg::grt_submode_t m, logic [9:0] r);
        arst_n = 1'b0;
        start_req = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1;
        check_val("cfg in reset", 32'h0, 32'(cfg));
        check_val("transmit in reset", 32'h0, 32'(transmit_pulse));
        arst_n = 1'b1;
        mode_in = m;
        range_in = r;
        start_req = 1'b1;
        measure(40, 6);
        check_val("interval sync", 32'h1, 32'(pulse_interval_sync));
        check_val("osc update", 32'h1, 32'(osc_update));
        check_val("execute", 32'h1, 32'(execute_mode));
    endtask

    // configuration once the new submode has reached the outputs
    task automatic check_cfg(grt_pkg::grt_submode_t m);
        check_val("cfg", cfg_exp(m) & cfg_mask(m),
            32'(cfg) & cfg_mask(m));
    endtask

    initial begin
        // drop reset before the first edge so nothing samples unknowns
        #1;
        // acquisition: window and gain gate from bin zero for 128 bins
        start_mode(grt_pkg::GRT_ACQ, 10'h000);
        check_val("transmit", 32'h1, 32'(transmit_pulse));
        check_val("blank", 32'h1, 32'(receiver_blank_pulse));
        check_val("start", 32'h1, 32'(sample_start_pulse));
        check_val("digital_gain_control", 32'h1, 32'(digital_gain_control_gate));
        measure(17000, 2);
        check_cfg(grt_pkg::GRT_ACQ);
        check_cnt("window", 16000, 16000, t[2]);
        check_cnt("window fall", t[2], t[2] + 1, t[4]);
        check_cnt("digital_gain_control length", 16000, 16000, t[3]);
        $display("test acquisition done");
        // monopulse, odd range: half bin delay, start at range / 2
        start_mode(grt_pkg::GRT_MONO, 10'h005);
        check_val("phase", 32'h0, 32'(phase_select));
        measure(2000, 2);
        check_cfg(grt_pkg::GRT_MONO);
        check_cnt("transmit delay", 60, 66, t[0]);
        check_cnt("blank delay", t[0], t[0], t[9]);
        check_cnt("start", 250, 250, t[1]);
        check_cnt("window", 1000, 1000, t[2] - t[1]);
        check_cnt("phase", -1, -1, t[7]);
        $display("test monopulse done");
        // split gate: half bins, 0.5 ms interval, no mid-cycle sync
        start_mode(grt_pkg::GRT_SPLIT, 10'h003);
        measure(63000, 5);
        check_cfg(grt_pkg::GRT_SPLIT);
        check_cnt("start", 185, 190, t[1]);
        check_cnt("window", 1000, 1000, t[2] - t[1]);
        check_cnt("interval", 62500, 62500, t[5]);
        check_cnt("next transmit", 62500, 62500, t[0]);
        check_cnt("process sync", -1, -1, t[6]);
        check_cnt("channel swap", t[5], t[5] + 2, t[8]);
        check_val("program request", 32'h0, 32'(program_request));
        $display("test split gate done");
        finish_test();
    end
endmodule
